// File: tbcu_pkg.sv
// tbcu_pkg: command word layouts, alignment codes, host-side register map
// and the dword arithmetic shared by both ends of the transmit buffer link.
// assumes nothing of its surroundings.
package tbcu_pkg;

  // ----------------------------------------------------------------------
  // first command word
  // ----------------------------------------------------------------------
  localparam int A_IRQ_BIT   = 31;
  localparam int A_ALIGN_HI  = 25;
  localparam int A_ALIGN_LO  = 24;
  localparam int A_OFF_HI    = 20;
  localparam int A_OFF_LO    = 16;
  localparam int A_FS_BIT    = 13;
  localparam int A_LS_BIT    = 12;
  localparam int LEN_HI      = 10;
  localparam logic [31:0] A_RSVD_MASK = 32'h7ce0_c800;

  // ----------------------------------------------------------------------
  // second command word
  // ----------------------------------------------------------------------
  localparam int B_TAG_HI    = 31;
  localparam int B_TAG_LO    = 16;
  localparam int B_NOCRC_BIT = 13;
  localparam int B_NOPAD_BIT = 12;
  localparam logic [31:0] B_RSVD_MASK = 32'h0000_c800;

  // ----------------------------------------------------------------------
  // end alignment codes, host limits
  // ----------------------------------------------------------------------
  localparam logic [1:0]  ALIGN_4       = 2'h0;
  localparam logic [1:0]  ALIGN_16      = 2'h1;
  localparam logic [1:0]  ALIGN_32      = 2'h2;
  localparam logic [7:0]  MAX_FRAGS     = 8'h56;
  localparam logic [10:0] MIN_MID_BYTES = 11'h004;

  // ----------------------------------------------------------------------
  // host register map and status bits
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CMD_A  = 4'h0;
  localparam logic [3:0] REG_CMD_B  = 4'h4;
  localparam logic [3:0] REG_DATA   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REJ_BIT  = 1;
  localparam int ST_OVR_BIT  = 2;

  // whole dwords a buffer occupies, offset and end filler included
  function automatic logic [9:0] total_dwords(logic [4:0] off, logic [1:0] align, logic [10:0] size);
    logic [11:0] span;
    logic [11:0] rnd;
    span = {7'h00, off} + {1'b0, size};
    unique case (align)
      ALIGN_16: rnd = (span + 12'h00f) & 12'hff0;
      ALIGN_32: rnd = (span + 12'h01f) & 12'hfe0;
      // reserved code 11 is taken as 4-byte alignment
      default:  rnd = (span + 12'h003) & 12'hffc;
    endcase
    return rnd[11:2];
  endfunction

  // dwords up to and including the last one holding payload
  function automatic logic [9:0] data_dwords(logic [4:0] off, logic [10:0] size);
    logic [11:0] lo;
    lo = {10'h000, off[1:0]} + {1'b0, size} + 12'h003;
    return lo[11:2] + {7'h00, off[4:2]};
  endfunction

endpackage

// File: tbcu_if.sv
// tbcu_if: dword stream from the host writer into the unpacker.
// assumes both ends share one clock; the word moves when valid and ready meet.
`timescale 1ns/10ps
interface tbcu_if;
  logic [31:0] data;
  logic        valid;
  logic        ready;

  modport host (output data, output valid, input ready);
  modport dev  (input data, input valid, output ready);
endinterface

// File: tbcu_unpacker.sv
// tbcu_unpacker: device end; strips command words, offset and filler dwords
// and feeds payload bytes to the mac side transmit queue.
// assumes the mac side queue stores a packet whole before it sends it.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps

// Functional notes
// - start offset field gives first byte
// - offset low bits pick first byte lane
// - offset high bits skip whole filler dwords
// - first and last segment flags
// - end filler computed from size, discarded
// - summed sizes checked against packet length
// - packet tag copied into status
// - crc disable bit suppresses crc
// - pad disable forces crc on
// - dwords after command words are offset filler, payload and end filler
// - unused trailing bytes not forwarded
// - host keeps middle buffers four bytes
// - host may start, end anywhere
// - host limits packet queue space 2036; the writer does not check packet length
// - whole packet queued before transmission
// - host may cap buffers at 86
// - host writes reserved bits zero
// - alignment codes 4, 16, 32 bytes
// - buffer loaded flag when requested
// - second word only with first segment
module tbcu_unpacker (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // dword stream from the host
  tbcu_if.dev              link,
  // byte stream to the mac side transmit queue
  output logic [7:0]       mac_byte,
  output logic             mac_valid,
  output logic             mac_last,
  input  wire logic        mac_ready,
  output logic             mac_no_crc,
  output logic             mac_no_pad,
  output logic             pkt_queued,
  // per packet status
  output logic             status_valid,
  output logic [15:0]      status_tag,
  output logic             status_err,
  // flags
  output logic             buffer_loaded_flag,
  output logic             transmit_error_flag,
  input  wire logic        txe_clear
);

  typedef enum logic [1:0] {S_CMDA, S_CMDB, S_WORD, S_EMIT} tbcu_state_t;

  tbcu_state_t state_q;
  logic [31:0] hold_q;
  logic [10:0] bytes_left_q;
  logic [9:0]  dw_left_q;
  logic [2:0]  skip_q;
  logic [1:0]  lane_q;
  logic [1:0]  in_lane_q;
  logic        first_q;
  logic        irq_q;
  logic        ls_q;
  logic [17:0] sum_q;
  logic [10:0] pkt_len_q;
  logic [15:0] tag_q;
  logic        no_crc_q;
  logic        no_pad_q;
  logic        loaded_q;
  logic        stat_v_q;
  logic [15:0] stat_tag_q;
  logic        stat_err_q;
  logic        queued_q;
  logic        txe_q;

  logic        take;
  logic        finish;
  logic        byte_go;
  logic        mismatch;
  logic [4:0]  a_off;
  logic [10:0] a_size;

  // ----------------------------------------------------------------------
  // stream handshake
  // ----------------------------------------------------------------------
  // a buffer ends only once every dword is taken and every byte is out,
  // which costs one idle cycle but keeps the status after the last byte
  assign finish  = (state_q == S_WORD) && (dw_left_q == 10'h000);
  assign link.ready = (state_q == S_CMDA) || (state_q == S_CMDB) ||
                      ((state_q == S_WORD) && (dw_left_q != 10'h000));
  assign take    = link.valid && link.ready;
  assign byte_go = (state_q == S_EMIT) && mac_ready;
  assign a_off   = link.data[tbcu_pkg::A_OFF_HI:tbcu_pkg::A_OFF_LO];
  assign a_size  = link.data[tbcu_pkg::LEN_HI:0];
  assign mismatch = sum_q != {7'h00, pkt_len_q};

  // ----------------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_CMDA;
    end else begin
      unique case (state_q)
        S_CMDA: begin
          if (take) begin
            // second word only with first segment
            state_q <= link.data[tbcu_pkg::A_FS_BIT] ? S_CMDB : S_WORD;
          end
        end
        S_CMDB: begin
          if (take) begin
            state_q <= S_WORD;
          end
        end
        S_WORD: begin
          if (finish) begin
            state_q <= S_CMDA;
          end else if (take && (skip_q == 3'h0) && (bytes_left_q != 11'h000)) begin
            state_q <= S_EMIT;
          end
        end
        S_EMIT: begin
          // back to S_WORD at the last counted byte or after the dword's top lane
          if (byte_go && ((bytes_left_q == 11'h001) || (in_lane_q == 2'h3))) begin
            state_q <= S_WORD;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // first command word and dword accounting
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dw_left_q <= 10'h000;
      skip_q    <= 3'h0;
      lane_q    <= 2'h0;
      irq_q     <= 1'b0;
      ls_q      <= 1'b0;
    end else if (state_q == S_CMDA && take) begin
      // whole buffer dwords from offset, size and alignment
      dw_left_q <= tbcu_pkg::total_dwords(a_off, link.data[tbcu_pkg::A_ALIGN_HI:tbcu_pkg::A_ALIGN_LO], a_size);
      skip_q    <= a_off[4:2];
      lane_q    <= a_off[1:0];
      irq_q     <= link.data[tbcu_pkg::A_IRQ_BIT];
      ls_q      <= link.data[tbcu_pkg::A_LS_BIT];
    end else if (state_q == S_WORD && take) begin
      dw_left_q <= dw_left_q - 10'h001;
      if (skip_q != 3'h0) begin
        skip_q <= skip_q - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // running byte sum per packet
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sum_q <= 18'h00000;
    end else if (state_q == S_CMDA && take) begin
      // sum restarts at the first segment
      if (link.data[tbcu_pkg::A_FS_BIT]) begin
        sum_q <= {7'h00, a_size};
      end else begin
        sum_q <= sum_q + {7'h00, a_size};
      end
    end
  end

  // ----------------------------------------------------------------------
  // second command word
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pkt_len_q <= 11'h000;
      tag_q     <= 16'h0000;
      no_crc_q  <= 1'b0;
      no_pad_q  <= 1'b0;
    end else if (state_q == S_CMDB && take) begin
      pkt_len_q <= link.data[tbcu_pkg::LEN_HI:0];
      // tag kept for the status word
      tag_q     <= link.data[tbcu_pkg::B_TAG_HI:tbcu_pkg::B_TAG_LO];
      // pad disable forces the crc back on
      no_crc_q  <= link.data[tbcu_pkg::B_NOCRC_BIT] && !link.data[tbcu_pkg::B_NOPAD_BIT];
      no_pad_q  <= link.data[tbcu_pkg::B_NOPAD_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // payload extraction
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q       <= 32'h0000_0000;
      bytes_left_q <= 11'h000;
      in_lane_q    <= 2'h0;
      first_q      <= 1'b0;
    end else if (state_q == S_CMDA && take) begin
      bytes_left_q <= a_size;
      first_q      <= 1'b1;
    end else if (state_q == S_WORD && take && skip_q == 3'h0 && bytes_left_q != 11'h000) begin
      // shift the first lane down to byte 0
      hold_q    <= first_q ? (link.data >> {lane_q, 3'b000}) : link.data;
      in_lane_q <= first_q ? lane_q : 2'h0;
      first_q   <= 1'b0;
    end else if (byte_go) begin
      hold_q       <= {8'h00, hold_q[31:8]};
      bytes_left_q <= bytes_left_q - 11'h001;
      in_lane_q    <= in_lane_q + 2'h1;
    end
  end

  assign mac_byte   = hold_q[7:0];
  assign mac_valid  = state_q == S_EMIT;
  assign mac_last   = (state_q == S_EMIT) && ls_q && (bytes_left_q == 11'h001);
  assign mac_no_crc = no_crc_q;
  assign mac_no_pad = no_pad_q;

  // ----------------------------------------------------------------------
  // buffer and packet completion
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_q   <= 1'b0;
      stat_v_q   <= 1'b0;
      queued_q   <= 1'b0;
      stat_tag_q <= 16'h0000;
      stat_err_q <= 1'b0;
    end else begin
      loaded_q <= finish && irq_q;
      stat_v_q <= finish && ls_q;
      // release the packet only once complete
      queued_q <= finish && ls_q;
      if (finish && ls_q) begin
        stat_tag_q <= tag_q;
        stat_err_q <= mismatch;
      end
    end
  end

  // error flag stays until cleared; a new mismatch beats the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      txe_q <= 1'b0;
    end else if (finish && ls_q && mismatch) begin
      txe_q <= 1'b1;
    end else if (txe_clear) begin
      txe_q <= 1'b0;
    end
  end

  assign buffer_loaded_flag  = loaded_q;
  assign status_valid        = stat_v_q;
  assign status_tag          = stat_tag_q;
  assign status_err          = stat_err_q;
  assign pkt_queued          = queued_q;
  assign transmit_error_flag = txe_q;

endmodule // tbcu_unpacker

// File: tbcu_host_writer.sv
// tbcu_host_writer: host end; takes command and data words from software
// registers, checks fragmentation, appends end filler, drives the stream.
// assumes software writes command A, then B for a first segment, then data.
`timescale 1ns/10ps
module tbcu_host_writer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // software register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // dword stream to the device
  tbcu_if.host             link
);

  logic [31:0] word_q;
  logic        valid_q;
  logic [9:0]  data_left_q;
  logic [9:0]  pad_pend_q;
  logic [9:0]  pad_left_q;
  logic [7:0]  frag_q;
  logic        b_ok_q;
  logic        drop_q;
  logic        rej_q;
  logic        ovr_q;
  logic [31:0] rdata_q;

  logic        slot_free;
  logic        sw_ok;
  logic        wr_a;
  logic        wr_b;
  logic        wr_d;
  logic        a_bad;
  logic        push_a;
  logic        push_b;
  logic        push_d;
  logic        push_pad;
  logic        reject;
  logic        overrun;
  logic [31:0] a_word;
  logic [7:0]  frag_next;

  // ----------------------------------------------------------------------
  // write decode and checks
  // ----------------------------------------------------------------------
  assign slot_free = !valid_q || link.ready;
  // software words wait for the filler to finish; no wait state exists,
  // so a write that finds the slot busy is refused and flagged
  assign sw_ok     = slot_free && (pad_left_q == 10'h000);
  assign wr_a      = reg_wr && reg_addr == tbcu_pkg::REG_CMD_A;
  assign wr_b      = reg_wr && reg_addr == tbcu_pkg::REG_CMD_B;
  assign wr_d      = reg_wr && reg_addr == tbcu_pkg::REG_DATA;
  assign a_word    = reg_wdata & ~tbcu_pkg::A_RSVD_MASK;
  assign frag_next = a_word[tbcu_pkg::A_FS_BIT] ? 8'h01 :
                     ((frag_q == 8'hff) ? frag_q : frag_q + 8'h01);
  assign a_bad     = (!a_word[tbcu_pkg::A_FS_BIT] && !a_word[tbcu_pkg::A_LS_BIT] &&
                      a_word[tbcu_pkg::LEN_HI:0] < tbcu_pkg::MIN_MID_BYTES) ||
                     (frag_next > tbcu_pkg::MAX_FRAGS);
  assign push_a    = wr_a && sw_ok && !a_bad;
  // second word only after a first segment
  assign push_b    = wr_b && sw_ok && b_ok_q;
  assign push_d    = wr_d && sw_ok && !b_ok_q && !drop_q && data_left_q != 10'h000;
  assign reject    = sw_ok && ((wr_a && a_bad) || (wr_b && !b_ok_q) ||
                     (wr_d && (b_ok_q || drop_q || data_left_q == 10'h000)));
  assign overrun   = (wr_a || wr_b || wr_d) && !sw_ok;
  assign push_pad  = slot_free && pad_left_q != 10'h000;

  // ----------------------------------------------------------------------
  // stream output
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      word_q  <= 32'h0000_0000;
      valid_q <= 1'b0;
    end else if (push_a) begin
      word_q  <= a_word;
      valid_q <= 1'b1;
    end else if (push_b) begin
      word_q  <= reg_wdata & ~tbcu_pkg::B_RSVD_MASK;
      valid_q <= 1'b1;
    end else if (push_d) begin
      word_q  <= reg_wdata;
      valid_q <= 1'b1;
    end else if (push_pad) begin
      word_q  <= 32'h0000_0000;
      valid_q <= 1'b1;
    end else if (link.ready) begin
      valid_q <= 1'b0;
    end
  end

  assign link.data  = word_q;
  assign link.valid = valid_q;

  // ----------------------------------------------------------------------
  // buffer tracking and end filler
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      data_left_q <= 10'h000;
      pad_pend_q  <= 10'h000;
      pad_left_q  <= 10'h000;
      frag_q      <= 8'h00;
      b_ok_q      <= 1'b0;
      drop_q      <= 1'b0;
    end else begin
      if (wr_a && sw_ok) begin
        drop_q <= a_bad;
      end
      if (push_a) begin
        data_left_q <= tbcu_pkg::data_dwords(a_word[tbcu_pkg::A_OFF_HI:tbcu_pkg::A_OFF_LO],
                                              a_word[tbcu_pkg::LEN_HI:0]);
        // filler up to the chosen alignment
        pad_pend_q  <= tbcu_pkg::total_dwords(a_word[tbcu_pkg::A_OFF_HI:tbcu_pkg::A_OFF_LO],
                                              a_word[tbcu_pkg::A_ALIGN_HI:tbcu_pkg::A_ALIGN_LO],
                                              a_word[tbcu_pkg::LEN_HI:0]) -
                       tbcu_pkg::data_dwords(a_word[tbcu_pkg::A_OFF_HI:tbcu_pkg::A_OFF_LO],
                                             a_word[tbcu_pkg::LEN_HI:0]);
        frag_q      <= frag_next;
        b_ok_q      <= a_word[tbcu_pkg::A_FS_BIT];
      end
      if (push_b) begin
        b_ok_q <= 1'b0;
      end
      if (push_d) begin
        data_left_q <= data_left_q - 10'h001;
        if (data_left_q == 10'h001) begin
          pad_left_q <= pad_pend_q;
        end
      end else if (push_pad) begin
        pad_left_q <= pad_left_q - 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status flags and read port
  // ----------------------------------------------------------------------
  // write-one-to-clear; an event in the same cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (rst) begin
      rej_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      if (reject) begin
        rej_q <= 1'b1;
      end else if (reg_wr && reg_addr == tbcu_pkg::REG_STATUS && reg_wdata[tbcu_pkg::ST_REJ_BIT]) begin
        rej_q <= 1'b0;
      end
      if (overrun) begin
        ovr_q <= 1'b1;
      end else if (reg_wr && reg_addr == tbcu_pkg::REG_STATUS && reg_wdata[tbcu_pkg::ST_OVR_BIT]) begin
        ovr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == tbcu_pkg::REG_STATUS) begin
      rdata_q <= {29'h0, ovr_q, rej_q, valid_q || pad_left_q != 10'h000};
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // tbcu_host_writer

// File: tbcu_checker.sv
// tbcu_checker: concurrent checks on the dword link between host writer and unpacker.
// assumes one clock for both ends and a synchronous active-high reset.
`timescale 1ns/10ps
module tbcu_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // link signals
  input wire logic [31:0] data,
  input wire logic        valid,
  input wire logic        ready
);
  // ----------------------------------------------------------------------
  // buffer position tracking
  // ----------------------------------------------------------------------
  logic        need_a_q, need_b_q, take, take_a, word, pay, last;
  logic [9:0]  idx_q, tot_q, dend_q;
  logic [2:0]  skip_q;
  logic [11:0] span, rnd, lo;
  assign take   = valid && ready;
  assign take_a = take && need_a_q;
  assign word   = take && !need_a_q && !need_b_q;
  assign pay    = word && idx_q >= {7'h00, skip_q} && idx_q < dend_q;
  assign last   = word && (idx_q + 10'h001 == tot_q);
  assign span   = {7'h00, data[20:16]} + {1'b0, data[10:0]};
  assign lo     = {10'h000, data[17:16]} + {1'b0, data[10:0]} + 12'h003;
  // reserved alignment code rounds like 4-byte
  always_comb begin
    case (data[25:24])
      2'h1:    rnd = (span + 12'h00f) & 12'hff0;
      2'h2:    rnd = (span + 12'h01f) & 12'hfe0;
      default: rnd = (span + 12'h003) & 12'hffc;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      need_a_q <= 1'b1;
      need_b_q <= 1'b0;
    end else if (take_a) begin
      need_a_q <= 1'b0;
      need_b_q <= data[13];
    end else if (take && need_b_q) begin
      need_b_q <= 1'b0;
    end else if (last) begin
      need_a_q <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (take_a) begin
      idx_q  <= 10'h000;
      tot_q  <= rnd[11:2];
      dend_q <= lo[11:2] + {7'h00, data[20:18]};
      skip_q <= data[20:18];
    end else if (word) begin
      idx_q <= idx_q + 10'h001;
    end
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |-> !valid && ready)
    else $error("link not idle after reset");
  a_hold_valid: assert property (valid && !ready |=> valid)
    else $error("valid dropped before taken");
  a_hold_data: assert property (valid && !ready |=> $stable(data))
    else $error("data changed before taken");
  a_cmdb_ready: assert property (take_a && data[13] |=> ready)
    else $error("second command word not awaited");
  a_mid_length: assert property (take_a && !data[13] && !data[12] |-> data[10:0] >= 11'h004)
    else $error("short middle buffer forwarded");
  a_rsvd_zero: assert property (take_a |-> (data & tbcu_pkg::A_RSVD_MASK) == 32'h0000_0000)
    else $error("reserved bits set in command word");
  a_payload_stall: assert property (pay |=> !ready)
    else $error("payload dword emitted no bytes");
  a_skip_fill: assert property (word && !pay && !last |=> ready)
    else $error("skipped dword stalled the link");
  a_finish_gap: assert property (last |=> !ready)
    else $error("no finish cycle after buffer");
  a_ready_back: assert property (last |-> ##[2:200] ready)
    else $error("link stuck after buffer end");
  a_filler_zero: assert property (word && idx_q >= dend_q |-> data == 32'h0000_0000)
    else $error("end filler not zero");
endmodule // tbcu_checker

// File: tbcu_tb_top.sv
// tbcu_tb_top: host writer and unpacker joined by the link; random packets with
// corner cases; byte stream, status and flags compared with a bench model.
// assumes a 100 MHz clock and the register map of tbcu_pkg.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin \
  n_checks++; \
  if ((gt) !== (ex)) begin \
    err_total++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module tbcu_tb_top;
  logic        clk, rst, reg_wr, reg_rd, mac_ready, txe_clear, exp_err, exp_nocrc, exp_nopad;
  logic        mac_valid, mac_last, mac_no_crc, mac_no_pad, pkt_queued;
  logic        status_valid, status_err, buffer_loaded_flag, transmit_error_flag;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, st;
  logic [7:0]  mac_byte;
  logic [15:0] status_tag, tag;
  logic [8:0]  exp_q[$];
  int          err_total, n_checks, n_stat, n_done, exp_done;

  tbcu_if tbcu_if_inst ();
  tbcu_host_writer tbcu_host_writer_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(tbcu_if_inst));
  tbcu_unpacker tbcu_unpacker_inst (.clk(clk), .rst(rst), .link(tbcu_if_inst), .mac_byte(mac_byte),
    .mac_valid(mac_valid), .mac_last(mac_last), .mac_ready(mac_ready), .mac_no_crc(mac_no_crc),
    .mac_no_pad(mac_no_pad), .pkt_queued(pkt_queued), .status_valid(status_valid), .status_tag(status_tag),
    .status_err(status_err), .buffer_loaded_flag(buffer_loaded_flag),
    .transmit_error_flag(transmit_error_flag), .txe_clear(txe_clear));
  tbcu_checker tbcu_checker_inst (.clk(clk), .rst(rst), .data(tbcu_if_inst.data),
    .valid(tbcu_if_inst.valid), .ready(tbcu_if_inst.ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // register port and buffer writing
  // ----------------------------------------------------------------------
  // a write waits while the link slot is held, else the host would drop it
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tbcu_if_inst.valid && !tbcu_if_inst.ready && n < 400);
    if (tbcu_if_inst.valid && !tbcu_if_inst.ready) begin
      err_total++;
      complete_run();
    end
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      rd(tbcu_pkg::REG_STATUS, st);
      n++;
    end while (st[0] !== 1'b0 && n < 300);
    if (st[0] !== 1'b0) begin
      err_total++;
      complete_run();
    end
  endtask

  task automatic send_buf(input int off, input int al, input int sz, input logic fs, input logic ls,
                          input logic irq, input logic [31:0] b);
    int dd, p;
    logic [31:0] w;
    idle();
    wr(tbcu_pkg::REG_CMD_A, {irq, 5'h00, 2'(al), 3'h0, 5'(off), 2'h0, fs, ls, 1'b0, 11'(sz)});
    if (fs) wr(tbcu_pkg::REG_CMD_B, b);
    dd = (off % 4 + sz + 3) / 4 + off / 4;
    for (int d = 0; d < dd; d++) begin
      w = rnd();
      for (int l = 0; l < 4; l++) begin
        p = d * 4 + l - off;
        if (p >= 0 && p < sz) exp_q.push_back({ls && p == sz - 1, w[8*l +: 8]});
      end
      wr(tbcu_pkg::REG_DATA, w);
    end
    exp_done += irq;
  endtask

  task automatic send_pkt(input int pk, input int nb);
    int sz[3], tot, m, n;
    logic [1:0] opt;
    tot = 0;
    opt = pk[1:0];
    for (int j = 0; j < nb; j++) begin
      sz[j] = (j == 0 || j == nb - 1) ? 1 + rnd() % 24 : 4 + rnd() % 20;
      tot += sz[j];
    end
    tag       = 16'(rnd());
    exp_err   = pk % 5 == 2;
    exp_nocrc = opt[1];
    exp_nopad = opt[0];
    m = n_stat;
    for (int j = 0; j < nb; j++)
      send_buf((j == 0 && pk == 1) ? 31 : rnd() % 32, (j == 0 && pk < 4) ? pk : rnd() % 4, sz[j],
               j == 0, j == nb - 1, rnd() % 2 == 1, {tag, 2'h0, opt, 1'b0, 11'(tot + exp_err)});
    for (n = 0; n < 600 && n_stat == m; n++) @(negedge clk);
    if (n_stat == m) begin
      err_total++;
      complete_run();
    end
    repeat (2) @(negedge clk);
    `CHK("error flag", exp_err, transmit_error_flag)
    @(posedge clk);
    txe_clear <= 1'b1;
    @(posedge clk);
    txe_clear <= 1'b0;
    @(negedge clk);
    `CHK("flag clear", 1'b0, transmit_error_flag)
    $display("packet %0d done", pk);
  endtask

  // ----------------------------------------------------------------------
  // mac side: random stalls, byte and status monitor
  // ----------------------------------------------------------------------
  always @(posedge clk) mac_ready <= (rnd() % 4) != 0;

  always @(negedge clk) begin
    if (!rst && mac_valid && mac_ready) begin
      if (exp_q.size() == 0) `CHK("spare byte", 1'b0, mac_valid)
      else begin
        `CHK("mac byte", exp_q[0][7:0], mac_byte)
        `CHK("mac last", exp_q[0][8], mac_last)
        void'(exp_q.pop_front());
      end
    end
    if (!rst && status_valid) begin
      n_stat++;
      `CHK("queued", 1'b1, pkt_queued)
      `CHK("queue left", 0, exp_q.size())
      `CHK("tag", tag, status_tag)
      `CHK("len err", exp_err, status_err)
      `CHK("no crc", exp_nocrc & !exp_nopad, mac_no_crc)
      `CHK("no pad", exp_nopad, mac_no_pad)
    end
    if (!rst && buffer_loaded_flag) n_done++;
  end

  initial begin
    seed      = 32'h0001_54a0;
    rst       = 1'b1;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    mac_ready = 1'b0;
    txe_clear = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // short middle buffer and stray data must be refused
    wr(tbcu_pkg::REG_CMD_A, 32'h0000_0002);
    wr(tbcu_pkg::REG_DATA, 32'h1234_5678);
    rd(tbcu_pkg::REG_STATUS, st);
    `CHK("reject", 3'h2, st[2:0])
    wr(tbcu_pkg::REG_STATUS, 32'h0000_0006);
    rd(4'h2, st);
    `CHK("unmapped", 32'h0000_0000, st)
    $display("refusal test done");
    for (int pk = 0; pk < 14; pk++) send_pkt(pk, 1 + rnd() % 3);
    idle();
    `CHK("loaded", exp_done, n_done)
    complete_run();
  end
endmodule // tbcu_tb_top
